// ---- verilog/port_two_cfg.svh ----
// Register map, field layout, reset values and bus codes for the port-two pin block.
// Contract
// - Mode bits 31..24 pick GPIO or special.
// - Direction bits 23..16 pick input or output.
// - Data field reads present pin levels.
// - Data writes act only on GPIO outputs.
// - Pin 5 special output drives inverted RTS.
// - Unused special combinations need nothing special.
// - Pin 4 output: SPI master enable when master.
// - Pin 4 output: receive clock when export set.
// - Pin 4 output: inverted general output one.
// - Pin 4 input: SPI slave clock when slave.
// - Pin 4 input: receive clock when source set.
// - Pin 3 input supplies receive data.
// - Pin 2 output: DMA acknowledge, low, request set.
// - Pin 2 input: inverted data-set-ready to serial.
// - Pin 1 input: inverted clear-to-send to serial.
// - Pin 0 output: DMA final low on last.
// - Pin 0 input: inverted carrier detect, software filters.
// - Pin 0 low input closes descriptor, interrupt.
`ifndef PORT_TWO_CFG_SVH
`define PORT_TWO_CFG_SVH

`define PT_CFG_ADDR 32'hFFB00024
`define PT_MODE_LSB 24
`define PT_DIR_LSB 16
`define PT_DATA_LSB 0
`define PT_MODE_RST 8'h00
`define PT_DIR_RST 8'h00
`define PT_DATA_RST 8'h00
`define PT_HTRANS_NONSEQ 2'h2
`define PT_HSIZE_WORD 3'h2
`define PT_HRESP_OKAY 1'b0

`endif

// ---- verilog/port_two_pkg.sv ----
// Types shared by the port-two pin block.
package port_two_pkg;

    // Pin personality, {mode, direction} in Gray order along the usual path.
    typedef enum logic [1:0]
    {
        PERS_GPIO_IN = 2'h0,
        PERS_GPIO_OUT = 2'h1,
        PERS_SF_OUT = 2'h3,
        PERS_SF_IN = 2'h2
    } pers_t;

endpackage : port_two_pkg

// ---- verilog/port_two_pin_function_config.sv ----
// Port-two configuration and data register with pin personality muxing, on AHB-Lite.
`include "port_two_cfg.svh"

module port_two_pin_function_config
    import port_two_pkg::*;
#(
    parameter int PIN_W = 8
)
(
    input wire logic CLK_I, // System clock, 50 MHz.
    input wire logic RSTN_I, // Asynchronous reset, active low.
    input wire logic HSEL_I, // Slave select.
    input wire logic [31:0] HADDR_I, // Byte address.
    input wire logic [1:0] HTRANS_I, // Transfer type.
    input wire logic HWRITE_I, // Write when high.
    input wire logic [2:0] HSIZE_I, // Transfer size.
    input wire logic [31:0] HWDATA_I, // Write data.
    input wire logic HREADY_I, // Bus ready.
    output logic [31:0] HRDATA_O, // Read data.
    output logic HREADYOUT_O, // Slave ready, always high.
    output logic HRESP_O, // Response, always OKAY.
    input wire logic [PIN_W-1:0] PIN_I, // Pad levels.
    output logic [PIN_W-1:0] PIN_O, // Pad drive levels.
    output logic [PIN_W-1:0] PIN_OE_O, // Pad drive enables, high drives.
    input wire logic CHB_TXD_I, // Channel B transmit data.
    input wire logic CHB_DTR_I, // Channel B terminal ready, active high.
    input wire logic CHB_RTS_I, // Channel B request to send, active high.
    input wire logic CHB_SPI_MASTER_I, // Channel B is SPI master.
    input wire logic CHB_SPI_SLAVE_I, // Channel B is SPI slave.
    input wire logic CHB_SPI_MEN_N_I, // SPI master enable, active low.
    input wire logic CHB_RX_CLK_I, // Channel B receiver clock.
    input wire logic CHB_OUT_ONE_I, // General output one, active high.
    input wire logic CHB_RX_CLK_EXPORT_I, // Receive clock export bit.
    input wire logic CHB_RX_CLK_SOURCE_I, // Receive clock source bit.
    output logic CHB_RXD_O, // Receive data to channel B.
    output logic CHB_SPI_SCLK_O, // SPI slave clock to channel B.
    output logic CHB_RX_CLK_EXT_O, // External receive clock to channel B.
    output logic CHB_DSR_O, // Data set ready, active high.
    output logic CHB_CTS_O, // Clear to send, active high.
    output logic CHB_DCD_O, // Carrier detect, active high.
    input wire logic DMA_EXT_REQ_I, // DMA channel 4 external request bit.
    input wire logic DMA_EXT_CYCLE_I, // External DMA cycle in progress.
    input wire logic DMA_LAST_I, // Cycle is final of descriptor.
    input wire logic DMA_DONE_IRQ_EN_I, // Interrupt enable for final input.
    output logic DMA_REQ_N_O, // DMA request from pin 6, active low.
    output logic DMA_CLOSE_O, // Close descriptor, one-cycle pulse.
    output logic DMA_DONE_IRQ_O // Interrupt request, one-cycle pulse.
);

    // Configuration state.
    logic [PIN_W-1:0] mode_r;
    logic [PIN_W-1:0] dir_r;
    logic [PIN_W-1:0] data_r;
    // Pad synchronisers.
    logic [PIN_W-1:0] pin_s1_r;
    logic [PIN_W-1:0] pin_s2_r;
    logic [PIN_W-1:0] pin_prev_r;
    // Bus pipeline.
    logic wr_dp_r;
    logic [31:0] rdata_r;
    logic addr_ok;
    logic wr_go;
    logic [PIN_W-1:0] gpo_mask;
    // Pin drive next values.
    logic [PIN_W-1:0] pin_nxt;
    logic [PIN_W-1:0] oe_nxt;
    logic [PIN_W-1:0] pin_r;
    logic [PIN_W-1:0] oe_r;
    // Serial and DMA outputs.
    logic rxd_r;
    logic sclk_r;
    logic rxclk_r;
    logic dsr_r;
    logic cts_r;
    logic dcd_r;
    logic dreq_n_r;
    logic close_r;
    logic irq_r;
    logic done_fall;

    // Personality of one pin from its mode and direction bits.
    function automatic pers_t pers(input logic [PIN_W-1:0] m, input logic [PIN_W-1:0] d,
                                   input int idx);
        pers = pers_t'({m[idx], d[idx]});
    endfunction : pers

    // A transfer to this block is started on a valid address phase.
    assign addr_ok = HSEL_I && HREADY_I && (HTRANS_I == `PT_HTRANS_NONSEQ);

    // Only a word write to the register address counts.
    assign wr_go = wr_dp_r;

    // Pins in GPIO output personality may take data writes.
    assign gpo_mask = ~mode_r & dir_r;

    // Zero wait states and always OKAY keep the slave trivially compliant.
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = `PT_HRESP_OKAY;
    assign HRDATA_O = rdata_r;

    // Two-flop pad synchroniser; the first stage feeds only the second.
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            pin_prev_r <= '0;
        end
        else
        begin
            pin_s1_r <= PIN_I;
            pin_s2_r <= pin_s1_r;
            pin_prev_r <= pin_s2_r;
        end
    end

    // Address phase: remember a write, capture read data for the next cycle.
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            wr_dp_r <= 1'b0;
            rdata_r <= 32'h00000000;
        end
        else
        begin
            wr_dp_r <= addr_ok && HWRITE_I && (HADDR_I == `PT_CFG_ADDR)
                       && (HSIZE_I == `PT_HSIZE_WORD);
            if (addr_ok && !HWRITE_I && (HADDR_I == `PT_CFG_ADDR))
            begin
                rdata_r <= {mode_r, dir_r, 8'h00, pin_s2_r};
            end
            else if (addr_ok && !HWRITE_I)
            begin
                rdata_r <= 32'h00000000;
            end
        end
    end

    // Mode and direction fields take the data phase word.
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            mode_r <= `PT_MODE_RST;
            dir_r <= `PT_DIR_RST;
        end
        else if (wr_go)
        begin
            mode_r <= HWDATA_I[`PT_MODE_LSB +: PIN_W];
            dir_r <= HWDATA_I[`PT_DIR_LSB +: PIN_W];
        end
    end

    // Data bits change only for pins that were GPIO outputs before the write.
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            data_r <= `PT_DATA_RST;
        end
        else if (wr_go)
        begin
            data_r <= (data_r & ~gpo_mask) | (HWDATA_I[`PT_DATA_LSB +: PIN_W] & gpo_mask);
        end
    end

    // Pad drive selection per personality; unused combinations leave the pad released.
    always_comb
    begin
        pin_nxt = data_r;
        oe_nxt = gpo_mask;
        for (int i = 0; i < PIN_W; i++)
        begin
            if (pers(mode_r, dir_r, i) == PERS_SF_OUT)
            begin
                case (i)
                    7:
                    begin
                        pin_nxt[i] = CHB_TXD_I;
                        oe_nxt[i] = 1'b1;
                    end
                    6:
                    begin
                        pin_nxt[i] = ~CHB_DTR_I;
                        oe_nxt[i] = 1'b1;
                    end
                    5:
                    begin
                        pin_nxt[i] = ~CHB_RTS_I;
                        oe_nxt[i] = 1'b1;
                    end
                    4:
                    begin
                        oe_nxt[i] = 1'b1;
                        if (CHB_SPI_MASTER_I)
                        begin
                            pin_nxt[i] = CHB_SPI_MEN_N_I;
                        end
                        else if (CHB_RX_CLK_EXPORT_I)
                        begin
                            pin_nxt[i] = CHB_RX_CLK_I;
                        end
                        else
                        begin
                            pin_nxt[i] = ~CHB_OUT_ONE_I;
                        end
                    end
                    2:
                    begin
                        pin_nxt[i] = ~(DMA_EXT_REQ_I && DMA_EXT_CYCLE_I);
                        oe_nxt[i] = 1'b1;
                    end
                    0:
                    begin
                        pin_nxt[i] = ~(DMA_EXT_REQ_I && DMA_EXT_CYCLE_I && DMA_LAST_I);
                        oe_nxt[i] = 1'b1;
                    end
                    default:
                    begin
                        pin_nxt[i] = 1'b0;
                        oe_nxt[i] = 1'b0;
                    end
                endcase
            end
        end
    end

    // Registered pad drive keeps the pads glitch free; costs one cycle of latency.
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            pin_r <= '0;
            oe_r <= '0;
        end
        else
        begin
            pin_r <= pin_nxt;
            oe_r <= oe_nxt;
        end
    end

    assign PIN_O = pin_r;
    assign PIN_OE_O = oe_r;

    // Special-function inputs to the serial channel and DMA, inverted where an active-low pad feeds an active-high input.
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            rxd_r <= 1'b1;
            sclk_r <= 1'b0;
            rxclk_r <= 1'b0;
            dsr_r <= 1'b0;
            cts_r <= 1'b0;
            dcd_r <= 1'b0;
            dreq_n_r <= 1'b1;
        end
        else
        begin
            rxd_r <= (pers(mode_r, dir_r, 3) == PERS_SF_IN) ? pin_s2_r[3] : 1'b1;
            sclk_r <= (pers(mode_r, dir_r, 4) == PERS_SF_IN) && CHB_SPI_SLAVE_I && pin_s2_r[4];
            rxclk_r <= (pers(mode_r, dir_r, 4) == PERS_SF_IN) && CHB_RX_CLK_SOURCE_I
                       && pin_s2_r[4];
            dsr_r <= (pers(mode_r, dir_r, 2) == PERS_SF_IN) && !pin_s2_r[2];
            cts_r <= (pers(mode_r, dir_r, 1) == PERS_SF_IN) && !pin_s2_r[1];
            dcd_r <= (pers(mode_r, dir_r, 0) == PERS_SF_IN) && !pin_s2_r[0];
            dreq_n_r <= (pers(mode_r, dir_r, 6) == PERS_SF_IN) ? pin_s2_r[6] : 1'b1;
        end
    end

    assign CHB_RXD_O = rxd_r;
    assign CHB_SPI_SCLK_O = sclk_r;
    assign CHB_RX_CLK_EXT_O = rxclk_r;
    assign CHB_DSR_O = dsr_r;
    assign CHB_CTS_O = cts_r;
    assign CHB_DCD_O = dcd_r;
    assign DMA_REQ_N_O = dreq_n_r;

    // Falling edge on a synchronised pin 0 marks the peripheral's final transfer.
    assign done_fall = pin_prev_r[0] && !pin_s2_r[0]
                       && (pers(mode_r, dir_r, 0) == PERS_SF_IN) && DMA_EXT_REQ_I;

    // One pulse per edge so a long low level closes only one descriptor.
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            close_r <= 1'b0;
            irq_r <= 1'b0;
        end
        else
        begin
            close_r <= done_fall;
            irq_r <= done_fall && DMA_DONE_IRQ_EN_I;
        end
    end

    assign DMA_CLOSE_O = close_r;
    assign DMA_DONE_IRQ_O = irq_r;

    a_mode_write: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        wr_go |=> mode_r == $past(HWDATA_I[31:24]))
        else $error("Mode field did not take the written value.");

    a_dir_write: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        wr_go |=> dir_r == $past(HWDATA_I[23:16]))
        else $error("Direction field did not take the written value.");

    a_data_read: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (addr_ok && !HWRITE_I && HADDR_I == `PT_CFG_ADDR)
        |=> HRDATA_O[7:0] == $past(pin_s2_r) && HRDATA_O[31:24] == $past(mode_r))
        else $error("Read data does not show pin levels.");

    a_data_guard: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        wr_go |=> ((data_r ^ $past(data_r)) & ~$past(gpo_mask)) == 8'h00)
        else $error("Data bit changed on a pin that is not a GPIO output.");

    a_rts_drive: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (mode_r[5] && dir_r[5]) |=> PIN_OE_O[5] && PIN_O[5] == !$past(CHB_RTS_I))
        else $error("Pin 5 does not drive inverted RTS.");

    // SPI master enable on pin 4
    a_spi_enable: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (mode_r[4] && dir_r[4] && CHB_SPI_MASTER_I) |=> PIN_O[4] == $past(CHB_SPI_MEN_N_I))
        else $error("Pin 4 does not drive SPI master enable.");

    a_rxclk_out: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (mode_r[4] && dir_r[4] && !CHB_SPI_MASTER_I && CHB_RX_CLK_EXPORT_I)
        |=> PIN_O[4] == $past(CHB_RX_CLK_I))
        else $error("Pin 4 does not drive the receive clock.");

    // general output one on pin 4
    a_general_output_one_drive: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (mode_r[4] && dir_r[4] && !CHB_SPI_MASTER_I && !CHB_RX_CLK_EXPORT_I)
        |=> PIN_O[4] == !$past(CHB_OUT_ONE_I))
        else $error("Pin 4 does not drive inverted general output one.");

    a_rxd_path: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (mode_r[3] && !dir_r[3]) |=> CHB_RXD_O == $past(pin_s2_r[3]))
        else $error("Receive data does not follow pin 3.");

    a_dack_low: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (mode_r[2] && dir_r[2] && DMA_EXT_REQ_I && DMA_EXT_CYCLE_I)
        |=> PIN_OE_O[2] && !PIN_O[2])
        else $error("DMA acknowledge not driven low.");

    a_dsr_path: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (mode_r[2] && !dir_r[2]) |=> CHB_DSR_O == !$past(pin_s2_r[2]))
        else $error("DSR is not the inverted pin 2 level.");

    // final output only on last cycle
    a_final_out: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (mode_r[0] && dir_r[0]) |=> PIN_O[0]
        == !$past(DMA_EXT_REQ_I && DMA_EXT_CYCLE_I && DMA_LAST_I))
        else $error("DMA final output wrong.");

    a_done_close: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (mode_r[0] && !dir_r[0] && DMA_EXT_REQ_I && $fell(pin_s2_r[0]))
        |=> DMA_CLOSE_O ##1 !DMA_CLOSE_O)
        else $error("Final input did not close the descriptor once.");

    a_reset_cfg: assert property (@(posedge CLK_I)
        $rose(RSTN_I) |-> mode_r == 8'h00 && dir_r == 8'h00 && PIN_OE_O == 8'h00)
        else $error("Configuration not cleared by reset.");

endmodule : port_two_pin_function_config

// ---- testbench/port_two_pad_model.sv ----
// Pad-side model: peripherals and modem lines that meet the eight port-two pins.
module port_two_pad_model
(
    input wire logic clk_i, // System clock.
    input wire logic [7:0] drive_i, // Device drive levels.
    input wire logic [7:0] drive_en_i, // Device drive enables.
    input wire logic [7:0] ext_val_i, // Peripheral levels.
    input wire logic [7:0] ext_en_i, // Peripheral drive enables.
    input wire logic final_pull_i, // Peripheral flags its last transfer.
    output logic [7:0] pad_o // Resolved pad levels.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] float_r = 8'h5A;
    logic [7:0] ext_lvl;
    logic [7:0] ext_on;

    // Released pads flip every cycle, so a stale level never passes for a driven one.
    always @(posedge clk_i)
    begin
        float_r <= ~float_r;
    end

    // Carrier detect rides the same pad.
    always_comb
    begin
        ext_lvl = ext_val_i;
        ext_on = ext_en_i;
        if (final_pull_i)
        begin
            ext_lvl[0] = 1'b0;
            ext_on[0] = 1'b1;
        end
    end

    // The device wins where it drives; clashes are not modelled.
    assign pad_o = (drive_en_i & drive_i) | (~drive_en_i & ext_on & ext_lvl)
        | (~drive_en_i & ~ext_on & float_r);
endmodule : port_two_pad_model

// ---- testbench/port_two_pin_function_config_bench.sv ----
// Self-checking bench for the port-two pin block with its pad model.
`include "port_two_cfg.svh"

module port_two_pin_function_config_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed
    {
        logic [8:0] ctl;
        logic [7:0] pins;
    } row_t;
    // Controls {rts, master, enable_n, rx clock, out one, export, req, cycle, last}.
    localparam row_t ROWS [10] = '{'{9'h180, 8'h05}, '{9'h0C0, 8'h35}, '{9'h128, 8'h15},
        '{9'h008, 8'h25}, '{9'h110, 8'h05}, '{9'h100, 8'h15}, '{9'h106, 8'h11},
        '{9'h107, 8'h10}, '{9'h103, 8'h15}, '{9'h105, 8'h15}};
    // Rows are {slave, source, pad pattern}.
    localparam logic [9:0] IN_CASE [3] = '{10'h312, 10'h0ED, 10'h0FF};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic hready;
    logic hresp;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic [7:0] pad;
    logic [7:0] ext_val = 8'hA5;
    logic [7:0] ext_en = 8'hFF;
    logic final_pull = 1'b0;
    logic [8:0] ctl = 9'h0;
    logic spi_slv = 1'b0;
    logic rx_src = 1'b0;
    logic irq_en = 1'b0;
    logic rxd, sclk, rxce, dsr, cts, dcd, req_n, close_p, irq_p;
    logic [5:0] exp6;
    int err_count = 0;
    int tests_run = 0;
    int n_close;
    int n_irq;

    // Half-period toggle gives 50 MHz.
    always #10 clk = ~clk;

    port_two_pin_function_config #(.PIN_W(8)) port_two_pin_function_config_i
    (
        .CLK_I(clk), .RSTN_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
        .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready),
        .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .PIN_I(pad),
        .PIN_O(pin_out), .PIN_OE_O(pin_oe), .CHB_TXD_I(1'b0), .CHB_DTR_I(1'b0),
        .CHB_RTS_I(ctl[8]), .CHB_SPI_MASTER_I(ctl[7]), .CHB_SPI_SLAVE_I(spi_slv),
        .CHB_SPI_MEN_N_I(ctl[6]), .CHB_RX_CLK_I(ctl[5]), .CHB_OUT_ONE_I(ctl[4]),
        .CHB_RX_CLK_EXPORT_I(ctl[3]), .CHB_RX_CLK_SOURCE_I(rx_src), .CHB_RXD_O(rxd),
        .CHB_SPI_SCLK_O(sclk), .CHB_RX_CLK_EXT_O(rxce), .CHB_DSR_O(dsr), .CHB_CTS_O(cts),
        .CHB_DCD_O(dcd), .DMA_EXT_REQ_I(ctl[2]), .DMA_EXT_CYCLE_I(ctl[1]),
        .DMA_LAST_I(ctl[0]), .DMA_DONE_IRQ_EN_I(irq_en), .DMA_REQ_N_O(req_n),
        .DMA_CLOSE_O(close_p), .DMA_DONE_IRQ_O(irq_p)
    );

    port_two_pad_model port_two_pad_model_i
    (
        .clk_i(clk), .drive_i(pin_out), .drive_en_i(pin_oe), .ext_val_i(ext_val),
        .ext_en_i(ext_en), .final_pull_i(final_pull), .pad_o(pad)
    );

    // Prints the counts and the verdict, then stops the run.
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    // Case-equality compare, so an unknown never passes.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Waits for ready at a rising edge; a slave that never answers ends the run.
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge clk);
        while (hready !== 1'b1)
        begin
            n++;
            if (n > 50)
            begin
                err_count++;
                tally_and_finish();
            end
            @(posedge clk);
        end
    endtask : wait_ready

    // One single transfer: address phase held to ready, then the data phase.
    task automatic xfer(input logic wr, input logic [2:0] size, input logic [31:0] addr,
        input logic [31:0] wd, output logic [31:0] rdv);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= addr;
        htrans <= `PT_HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= size;
        wait_ready();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        wait_ready();
        rdv = hrdata;
    endtask : xfer

    // Main sequence: reset, bus and GPIO checks first, then the table rows, then the awkward cases.
    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        check("oe_reset", {24'h0, pin_oe}, 32'h0); // Pins released.
        xfer(1'b0, 3'h2, `PT_CFG_ADDR, 32'h0, rd);
        check("cfg_reset", rd, 32'h000000A5); // Fields clear.
        check("hresp", {31'h0, hresp}, 32'h0); // Response is OKAY.
        ext_en <= 8'hF0;
        xfer(1'b1, 3'h2, `PT_CFG_ADDR, 32'h000F0000, rd);
        xfer(1'b1, 3'h2, `PT_CFG_ADDR, 32'h000F00C9, rd);
        xfer(1'b1, 3'h0, `PT_CFG_ADDR, 32'h000F0006, rd);
        repeat (4) @(posedge clk);
        xfer(1'b0, 3'h2, `PT_CFG_ADDR, 32'h0, rd);
        check("gpio_read", rd, 32'h000F00A9); // Mixed pins.
        check("gpio_drive", {16'h0, pin_oe, pin_out}, 32'h00000F09); // Outputs.
        ext_en <= 8'h00;
        xfer(1'b1, 3'h2, `PT_CFG_ADDR, 32'h00FF0000, rd);
        xfer(1'b1, 3'h2, `PT_CFG_ADDR, 32'h0FFF00FF, rd);
        xfer(1'b1, 3'h2, `PT_CFG_ADDR, 32'h00FF0000, rd);
        xfer(1'b1, 3'h2, `PT_CFG_ADDR + 32'h4, 32'hFFFFFFFF, rd);
        xfer(1'b0, 3'h2, `PT_CFG_ADDR + 32'h4, 32'h0, rd);
        check("unmapped", rd, 32'h0); // Unmapped word.
        repeat (2) @(posedge clk);
        xfer(1'b0, 3'h2, `PT_CFG_ADDR, 32'h0, rd);
        check("masked_data", rd, 32'h00FF000F); // Specials ignored.
        ext_en <= 8'hFF;
        xfer(1'b1, 3'h2, `PT_CFG_ADDR, 32'h3F3F0000, rd);
        foreach (ROWS[i])
        begin
            @(posedge clk);
            ctl <= ROWS[i].ctl;
            repeat (2) @(posedge clk);
            @(negedge clk);
            check("sf_out", {pin_oe, pin_out & 8'h35},
                {8'h35, ROWS[i].pins});
        end
        xfer(1'b1, 3'h2, `PT_CFG_ADDR, 32'hFF000000, rd);
        foreach (IN_CASE[k])
        begin
            @(posedge clk);
            {spi_slv, rx_src, ext_val} <= IN_CASE[k];
            repeat (4) @(posedge clk);
            @(negedge clk);
            exp6 = {ext_val[3], spi_slv & ext_val[4], rx_src & ext_val[4], ~ext_val[2:0]};
            check("sf_in", {26'h0, rxd, sclk, rxce, dsr, cts, dcd},
                {26'h0, exp6});
            check("req_n", {31'h0, req_n}, {31'h0, ext_val[6]}); // Pin 6 input.
        end
        for (int k = 0; k < 3; k++)
        begin
            @(posedge clk);
            ctl <= {6'h0, k != 2, 2'h0};
            irq_en <= (k != 1);
            repeat (4) @(posedge clk);
            final_pull <= 1'b1;
            n_close = 0;
            n_irq = 0;
            repeat (8)
            begin
                @(negedge clk);
                n_close += int'(close_p === 1'b1);
                n_irq += int'(irq_p === 1'b1);
            end
            @(posedge clk);
            final_pull <= 1'b0;
            check("close", 32'(n_close), 32'(k != 2)); // One close per final while request is set.
            check("irq", 32'(n_irq), 32'(k == 0)); // Interrupt when enabled and request set.
        end
        xfer(1'b1, 3'h2, `PT_CFG_ADDR, 32'h00FF0000, rd);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("oe_midreset", {24'h0, pin_oe}, 32'h0); // Drive dropped.
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        xfer(1'b0, 3'h2, `PT_CFG_ADDR, 32'h0, rd);
        check("cfg_midreset", rd & 32'hFFFF0000, 32'h0); // Fields clear again.
        tally_and_finish();
    end
endmodule : port_two_pin_function_config_bench
